// ---- psc_pkg.sv ----
package psc_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD = 9600;
	localparam int BAUD_DIV = (CLK_HZ + BAUD / 2) / BAUD;
	localparam int BLINK_HALF_MS = 1000;
	localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int LONG_PRESS_MS = 1000;
	localparam int LONG_PRESS_CYC = CLK_HZ / 1000 * LONG_PRESS_MS;
	localparam int LINE_MAX = 24;
	localparam int NAME_MAX = 8;
	localparam int NAME_BYTES = 12;
	localparam int ARG_POS_NUM = 5;
	localparam int ARG_POS_CD = 9;
	localparam int ARG_POS_PLAY = 10;
	localparam logic [7:0] VOL_RESET = 8'h28;
	localparam logic [7:0] VOL_QUIETEST = 8'hfe;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	// Long keywords held as byte codes, right aligned like the short ones
	localparam logic [79:0] KW_CD_NAME = 80'h434449524e414d4520;
	localparam logic [79:0] KW_CD_NUM = 80'("cnum ");
	localparam logic [79:0] KW_PLAY_NAME = 80'h50534f4e474e414d4520;
	localparam logic [79:0] KW_PLAY_NUM = 80'("pnum ");
	localparam logic [79:0] KW_OFF = 80'("OFF");
	localparam logic [79:0] KW_ON = 80'("ON");
	localparam logic [31:0] EXT_MP3 = ".MP3";
	localparam int MSG_LEN = 84;
	localparam logic [8*MSG_LEN-1:0] MSG_ROM = {"Stopped.\015\012", "Paused\015\012", "Playing\015\012",
		" <DIR>", "L ", 64'h434449524e414d45, " cnum . ", 72'h50534f4e474e414d45, " pnum OFF ON C + - p ?\015\012"};
	localparam logic [6:0] MSG_STOP_AT = 7'h00;
	localparam logic [6:0] MSG_PAUSE_AT = 7'h0a;
	localparam logic [6:0] MSG_PLAY_AT = 7'h12;
	localparam logic [6:0] MSG_DIR_AT = 7'h1b;
	localparam logic [6:0] MSG_HELP_AT = 7'h21;
	localparam logic [6:0] MSG_END = 7'h54;
	typedef enum logic [2:0] {FS_LIST, FS_CD_NAME, FS_CD_INDEX, FS_PARENT, FS_PLAY_NAME, FS_PLAY_INDEX,
		FS_NEXT, FS_PREV} psc_fs_op_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT, ST_MSG} psc_state_t;
endpackage

// ---- psc_uart.sv ----
`timescale 1ns/1ps
module psc_uart (
	input wire logic clk,
	input wire logic rst,
	input wire logic rx,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx
);
	localparam logic [10:0] DIV_M1 = 11'(psc_pkg::BAUD_DIV - 1);
	localparam logic [10:0] DIV_HALF = 11'(psc_pkg::BAUD_DIV / 2);
	logic [10:0] rx_cnt_r;
	logic [3:0] rx_bit_r;
	logic [7:0] rx_sh_r;
	logic rx_busy_r;
	logic [9:0] tx_sh_r;
	logic [3:0] tx_left_r;
	logic [10:0] tx_cnt_r;

	// Receiver samples mid-bit; bad stop bit drops the byte
	always_ff @(posedge clk) begin
		rx_valid <= 1'b0;
		if (rst) begin
			rx_busy_r <= 1'b0;
			rx_cnt_r <= 11'h000;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 8'h00;
			rx_data <= 8'h00;
		end else if (!rx_busy_r) begin
			if (!rx) begin
				rx_busy_r <= 1'b1;
				rx_cnt_r <= DIV_HALF;
				rx_bit_r <= 4'h0;
			end
		end else if (rx_cnt_r != 11'h000) begin
			rx_cnt_r <= rx_cnt_r - 11'h001;
		end else begin
			rx_cnt_r <= DIV_M1;
			rx_bit_r <= rx_bit_r + 4'h1;
			if (rx_bit_r == 4'h0) begin
				if (rx) rx_busy_r <= 1'b0; // Glitch, not a start bit
			end else if (rx_bit_r < 4'h9) begin
				rx_sh_r <= {rx, rx_sh_r[7:1]}; // LSB first
			end else begin
				rx_busy_r <= 1'b0;
				if (rx) begin
					rx_data <= rx_sh_r;
					rx_valid <= 1'b1;
				end
			end
		end
	end

	// Transmitter: start, eight data, one stop
	assign tx_ready = (tx_left_r == 4'h0);
	assign tx = tx_sh_r[0];
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_sh_r <= 10'h3ff;
			tx_left_r <= 4'h0;
			tx_cnt_r <= 11'h000;
		end else if (tx_ready) begin
			if (tx_valid) begin
				tx_sh_r <= {1'b1, tx_data, 1'b0};
				tx_left_r <= 4'ha;
				tx_cnt_r <= DIV_M1;
			end
		end else if (tx_cnt_r != 11'h000) begin
			tx_cnt_r <= tx_cnt_r - 11'h001;
		end else begin
			tx_sh_r <= {1'b1, tx_sh_r[9:1]};
			tx_left_r <= tx_left_r - 4'h1;
			tx_cnt_r <= DIV_M1;
		end
	end
endmodule // psc_uart

// ---- psc_serial_cmd_parser.sv ----
`timescale 1ns/1ps
module psc_serial_cmd_parser #(
	parameter int BLINK_HALF_CYC = psc_pkg::BLINK_HALF_CYC,
	parameter int LONG_PRESS_CYC = psc_pkg::LONG_PRESS_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic route_serial,
	input wire logic decoder_request_or_serial_rx_in,
	output logic decoder_request_or_serial_rx_out,
	output logic decoder_request_or_serial_rx_oe,
	input wire logic decoder_reset_or_serial_tx_in,
	output logic decoder_reset_or_serial_tx_out,
	output logic decoder_reset_or_serial_tx_oe,
	input wire logic decoder_request,
	output logic decoder_reset,
	output logic decoder_power,
	output logic play_stop,
	output logic play_paused,
	output logic [7:0] volume,
	output logic fs_req,
	output psc_pkg::psc_fs_op_t fs_op,
	output logic [95:0] fs_name,
	output logic [7:0] fs_num,
	input wire logic fs_done,
	input wire logic fs_ok,
	input wire logic [7:0] fs_char,
	input wire logic fs_char_valid,
	output logic fs_char_ready,
	input wire logic fs_dir_mark,
	input wire logic fs_end,
	input wire logic stick_toward_power_jack,
	input wire logic stick_toward_headphones,
	input wire logic stick_pressed,
	input wire logic mass_storage,
	input wire logic card_activity,
	input wire logic ext_power,
	input wire logic batt_below_3v3,
	input wire logic charging,
	output logic play_status_lamp,
	output logic battery_level_lamp
);
	psc_pkg::psc_state_t state_r;
	logic [7:0] line_r [psc_pkg::LINE_MAX];
	logic [4:0] len_r;
	logic ovf_r;
	logic line_done;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_line;
	logic tx_bit;
	logic tx_ready;
	logic tx_valid;
	logic [7:0] tx_data;
	logic [6:0] msg_idx_r;
	logic [6:0] msg_end_r;
	psc_pkg::psc_state_t msg_ret_r;
	logic playing_r;
	logic paused_r;
	logic [7:0] vol_r;
	logic power_r;
	logic [7:0] depth_r;
	logic c_list, c_cd_name, c_cd_num, c_up, c_play_name, c_play_num;
	logic c_off, c_on, c_stop, c_louder, c_softer, c_pause, c_help;
	logic fs_go;
	psc_pkg::psc_fs_op_t fs_go_op;
	logic [8:0] num_arg;
	logic [95:0] name_arg;
	logic [2:0] joy_in;
	logic [2:0] joy_short;
	logic [2:0] joy_long;
	logic vol_up_req, vol_dn_req, pause_tgl;
	logic [23:0] blink_cnt_r;
	logic blink_r;

	// Strap routing of the shared pins
	assign rx_line = route_serial ? decoder_request_or_serial_rx_in : 1'b1;
	assign decoder_request_or_serial_rx_out = decoder_request;
	assign decoder_request_or_serial_rx_oe = !route_serial;
	assign decoder_reset_or_serial_tx_out = tx_bit;
	assign decoder_reset_or_serial_tx_oe = route_serial;
	assign decoder_reset = route_serial ? 1'b0 : decoder_reset_or_serial_tx_in;
	assign decoder_power = power_r;
	assign play_paused = paused_r;
	assign volume = vol_r;

	psc_uart u_uart (
		.clk(clk),
		.rst(rst),
		.rx(rx_line),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.tx(tx_bit)
	);

	// Exact byte compare, so letter case matters
	function automatic logic has_prefix(input logic [79:0] kw, input int n);
		logic ok;
		ok = (int'(len_r) >= n);
		for (int i = 0; i < 10; i++) begin
			if (i < n && line_r[i] != kw[8 * (n - 1 - i) +: 8]) ok = 1'b0;
		end
		return ok;
	endfunction

	// Decimal argument of one to three digits, 0..255; bit 8 flags valid
	function automatic logic [8:0] parse_num(input int p);
		logic [9:0] v;
		logic ok;
		v = 10'h000;
		ok = (int'(len_r) > p) && (int'(len_r) <= p + 3);
		for (int i = 0; i < 3; i++) begin
			if (p + i < int'(len_r)) begin
				if (line_r[p + i] < psc_pkg::CH_ZERO || line_r[p + i] > psc_pkg::CH_NINE) ok = 1'b0;
				v = 10'(v * 10 + 10'(line_r[p + i] - psc_pkg::CH_ZERO));
			end
		end
		if (v > 10'h0ff) ok = 1'b0;
		return {ok, v[7:0]};
	endfunction

	// Name argument, left aligned and zero padded
	function automatic logic [95:0] grab_name(input int p);
		logic [95:0] n;
		n = 96'h0;
		for (int i = 0; i < psc_pkg::NAME_BYTES; i++) begin
			if (p + i < int'(len_r)) n[8 * (11 - i) +: 8] = line_r[p + i];
		end
		return n;
	endfunction

	// Command decode of a finished line
	always_comb begin
		num_arg = parse_num(psc_pkg::ARG_POS_NUM);
		c_list = (len_r == 5'h01) && (line_r[0] == "L");
		c_up = (len_r == 5'h01) && (line_r[0] == ".");
		c_stop = (len_r == 5'h01) && (line_r[0] == "C");
		c_louder = (len_r == 5'h01) && (line_r[0] == "+");
		c_softer = (len_r == 5'h01) && (line_r[0] == "-");
		c_pause = (len_r == 5'h01) && (line_r[0] == "p");
		c_help = (len_r == 5'h01) && (line_r[0] == "?");
		c_cd_name = has_prefix(psc_pkg::KW_CD_NAME, psc_pkg::ARG_POS_CD)
			&& int'(len_r) <= psc_pkg::ARG_POS_CD + psc_pkg::NAME_MAX && int'(len_r) > psc_pkg::ARG_POS_CD;
		c_cd_num = has_prefix(psc_pkg::KW_CD_NUM, psc_pkg::ARG_POS_NUM) && num_arg[8];
		c_play_num = has_prefix(psc_pkg::KW_PLAY_NUM, psc_pkg::ARG_POS_NUM) && num_arg[8];
		// Base of one to eight characters plus the MP3 extension
		c_play_name = has_prefix(psc_pkg::KW_PLAY_NAME, psc_pkg::ARG_POS_PLAY)
			&& int'(len_r) >= psc_pkg::ARG_POS_PLAY + 5 && int'(len_r) <= psc_pkg::ARG_POS_PLAY + 12
			&& {line_r[len_r - 5'h04], line_r[len_r - 5'h03], line_r[len_r - 5'h02], line_r[len_r - 5'h01]}
			== psc_pkg::EXT_MP3;
		// Argument start depends on the decoded keyword, so it comes after it
		name_arg = grab_name(c_play_name ? psc_pkg::ARG_POS_PLAY : psc_pkg::ARG_POS_CD);
		c_off = (len_r == 5'h03) && has_prefix(psc_pkg::KW_OFF, 3);
		c_on = (len_r == 5'h02) && has_prefix(psc_pkg::KW_ON, 2);
		fs_go = 1'b1;
		fs_go_op = psc_pkg::FS_LIST;
		if (c_cd_name) fs_go_op = psc_pkg::FS_CD_NAME;
		else if (c_cd_num) fs_go_op = psc_pkg::FS_CD_INDEX;
		else if (c_up && depth_r != 8'h00) fs_go_op = psc_pkg::FS_PARENT; // Root stays put
		else if (c_play_name) fs_go_op = psc_pkg::FS_PLAY_NAME;
		else if (c_play_num) fs_go_op = psc_pkg::FS_PLAY_INDEX;
		else if (!c_list) fs_go = 1'b0;
	end

	// Line assembly; CR dropped so LF and CR LF end alike
	assign line_done = rx_valid && rx_data == psc_pkg::CH_LF && state_r == psc_pkg::ST_IDLE
		&& len_r != 5'h00 && !ovf_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			len_r <= 5'h00;
			ovf_r <= 1'b0;
		end else if (state_r == psc_pkg::ST_EXEC) begin
			len_r <= 5'h00;
			ovf_r <= 1'b0;
		end else if (rx_valid && state_r == psc_pkg::ST_IDLE) begin
			if (rx_data == psc_pkg::CH_LF) begin
				if (!line_done) begin
					len_r <= 5'h00;
					ovf_r <= 1'b0;
				end
			end else if (rx_data != psc_pkg::CH_CR) begin
				if (len_r < 5'(psc_pkg::LINE_MAX)) begin
					line_r[len_r] <= rx_data;
					len_r <= len_r + 5'h01;
				end else begin
					ovf_r <= 1'b1; // Overlong line is thrown away at its end
				end
			end
		end
	end

	// Reply source: card agent text while waiting, message ROM otherwise
	assign fs_char_ready = (state_r == psc_pkg::ST_WAIT) && tx_ready;
	assign tx_valid = (state_r == psc_pkg::ST_MSG) || (state_r == psc_pkg::ST_WAIT && fs_char_valid);
	assign tx_data = (state_r == psc_pkg::ST_MSG)
		? psc_pkg::MSG_ROM[8 * (psc_pkg::MSG_LEN - 1 - int'(msg_idx_r)) +: 8] : fs_char;

	// Sequencer; new lines are ignored until the current command finishes
	always_ff @(posedge clk) begin
		fs_req <= 1'b0;
		if (rst) begin
			state_r <= psc_pkg::ST_IDLE;
			fs_op <= psc_pkg::FS_LIST;
			fs_name <= 96'h0;
			fs_num <= 8'h00;
			msg_idx_r <= 7'h00;
			msg_end_r <= 7'h00;
			msg_ret_r <= psc_pkg::ST_IDLE;
		end else begin
			case (state_r)
				psc_pkg::ST_IDLE: begin
					if (line_done) begin
						state_r <= psc_pkg::ST_EXEC;
					end else if (joy_short[0] || joy_short[1]) begin
						fs_req <= 1'b1;
						fs_op <= joy_short[0] ? psc_pkg::FS_NEXT : psc_pkg::FS_PREV;
						state_r <= psc_pkg::ST_WAIT;
					end
				end
				psc_pkg::ST_EXEC: begin
					msg_ret_r <= psc_pkg::ST_IDLE;
					state_r <= psc_pkg::ST_IDLE;
					if (fs_go) begin
						fs_req <= 1'b1;
						fs_op <= fs_go_op;
						fs_name <= name_arg;
						fs_num <= num_arg[7:0];
						state_r <= psc_pkg::ST_WAIT;
					end else if (c_stop && playing_r) begin
						msg_idx_r <= psc_pkg::MSG_STOP_AT;
						msg_end_r <= psc_pkg::MSG_PAUSE_AT;
						state_r <= psc_pkg::ST_MSG;
					end else if (c_pause && playing_r) begin
						msg_idx_r <= paused_r ? psc_pkg::MSG_PLAY_AT : psc_pkg::MSG_PAUSE_AT;
						msg_end_r <= paused_r ? psc_pkg::MSG_DIR_AT : psc_pkg::MSG_PLAY_AT;
						state_r <= psc_pkg::ST_MSG;
					end else if (c_help) begin
						msg_idx_r <= psc_pkg::MSG_HELP_AT;
						msg_end_r <= psc_pkg::MSG_END;
						state_r <= psc_pkg::ST_MSG;
					end
				end
				psc_pkg::ST_WAIT: begin
					if (fs_done) begin
						state_r <= psc_pkg::ST_IDLE;
					end else if (fs_dir_mark) begin
						msg_idx_r <= psc_pkg::MSG_DIR_AT; // Directory tag in listing
						msg_end_r <= psc_pkg::MSG_HELP_AT;
						msg_ret_r <= psc_pkg::ST_WAIT;
						state_r <= psc_pkg::ST_MSG;
					end
				end
				psc_pkg::ST_MSG: begin
					if (tx_ready) begin
						msg_idx_r <= msg_idx_r + 7'h01;
						if (msg_idx_r + 7'h01 == msg_end_r) state_r <= msg_ret_r;
					end
				end
				default: state_r <= psc_pkg::ST_IDLE;
			endcase
		end
	end

	// Stick decode: one counter per direction, long press fires once
	assign joy_in = {stick_pressed, stick_toward_headphones, stick_toward_power_jack};
	for (genvar g = 0; g < 3; g++) begin : g_stick
		logic [23:0] hold_r;
		logic long_r;
		always_ff @(posedge clk) begin
			joy_short[g] <= 1'b0;
			joy_long[g] <= 1'b0;
			if (rst) begin
				hold_r <= 24'h000000;
				long_r <= 1'b0;
			end else if (joy_in[g]) begin
				if (!long_r) hold_r <= hold_r + 24'h000001;
				if (!long_r && hold_r == 24'(LONG_PRESS_CYC - 1)) begin
					long_r <= 1'b1;
					joy_long[g] <= 1'b1;
				end
			end else begin
				if (hold_r != 24'h000000 && !long_r) joy_short[g] <= 1'b1;
				hold_r <= 24'h000000;
				long_r <= 1'b0;
			end
		end
	end

	// Playback controls honoured only once playback is started
	assign vol_up_req = playing_r && ((state_r == psc_pkg::ST_EXEC && c_louder) || joy_long[0]);
	assign vol_dn_req = playing_r && ((state_r == psc_pkg::ST_EXEC && c_softer) || joy_long[1]);
	assign pause_tgl = playing_r && ((state_r == psc_pkg::ST_EXEC && c_pause) || joy_short[2]);

	// Playback, volume, power and directory depth
	always_ff @(posedge clk) begin
		play_stop <= 1'b0;
		if (rst) begin
			playing_r <= 1'b0;
			paused_r <= 1'b0;
			vol_r <= psc_pkg::VOL_RESET;
			power_r <= 1'b1;
			depth_r <= 8'h00;
		end else begin
			if (state_r == psc_pkg::ST_EXEC && c_off) power_r <= 1'b0;
			if (state_r == psc_pkg::ST_EXEC && c_on) power_r <= 1'b1;
			// Lower setting is louder; both ends saturate
			if (vol_up_req && vol_r != 8'h00) vol_r <= vol_r - 8'h01;
			if (vol_dn_req && vol_r < psc_pkg::VOL_QUIETEST) vol_r <= vol_r + 8'h01;
			if (pause_tgl) paused_r <= !paused_r;
			if (state_r == psc_pkg::ST_EXEC && c_stop && playing_r) begin
				playing_r <= 1'b0;
				paused_r <= 1'b0;
				play_stop <= 1'b1;
			end
			if (fs_end) begin
				playing_r <= 1'b0;
				paused_r <= 1'b0;
			end
			if (state_r == psc_pkg::ST_WAIT && fs_done && fs_ok) begin
				case (fs_op)
					psc_pkg::FS_PLAY_NAME, psc_pkg::FS_PLAY_INDEX, psc_pkg::FS_NEXT, psc_pkg::FS_PREV: begin
						playing_r <= 1'b1;
						paused_r <= 1'b0;
					end
					psc_pkg::FS_CD_NAME, psc_pkg::FS_CD_INDEX: begin
						if (depth_r != 8'hff) depth_r <= depth_r + 8'h01;
					end
					psc_pkg::FS_PARENT: depth_r <= depth_r - 8'h01;
					default: depth_r <= depth_r;
				endcase
			end
		end
	end

	// Shared 1 s half-period blink, registered lamps
	always_ff @(posedge clk) begin
		if (rst) begin
			blink_cnt_r <= 24'h000000;
			blink_r <= 1'b0;
			play_status_lamp <= 1'b0;
			battery_level_lamp <= 1'b0;
		end else begin
			if (blink_cnt_r == 24'(BLINK_HALF_CYC - 1)) begin
				blink_cnt_r <= 24'h000000;
				blink_r <= !blink_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 24'h000001;
			end
			if (mass_storage) play_status_lamp <= card_activity;
			else play_status_lamp <= playing_r && (!paused_r || blink_r);
			if (ext_power) battery_level_lamp <= charging;
			else battery_level_lamp <= batt_below_3v3 && blink_r;
		end
	end
endmodule // psc_serial_cmd_parser

// ---- psc_parser_assertions.sv ----
`timescale 1ns/1ps
module psc_parser_assertions #(
	parameter int BLINK_HALF_CYC = 20,
	parameter int LONG_PRESS_CYC = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic route_serial,
	input wire logic decoder_request_or_serial_rx_out,
	input wire logic decoder_request_or_serial_rx_oe,
	input wire logic decoder_reset_or_serial_tx_in,
	input wire logic decoder_reset_or_serial_tx_out,
	input wire logic decoder_reset_or_serial_tx_oe,
	input wire logic decoder_request,
	input wire logic decoder_reset,
	input wire logic [7:0] volume,
	input wire logic fs_req,
	input psc_pkg::psc_fs_op_t fs_op,
	input wire logic play_stop,
	input wire logic play_paused,
	input wire logic mass_storage,
	input wire logic card_activity,
	input wire logic ext_power,
	input wire logic charging,
	input wire logic play_status_lamp,
	input wire logic battery_level_lamp
);
	// Slack of two cycles for the registered lamp
	localparam int BLINK_WIN = BLINK_HALF_CYC + 2;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_TX_OE: assert property (decoder_reset_or_serial_tx_oe == route_serial)
		else $error("tx enable does not follow strap");
	AST_PIN3_PASS: assert property (!route_serial |-> decoder_request_or_serial_rx_oe &&
		decoder_request_or_serial_rx_out == decoder_request) else $error("request pin not passed through");
	AST_RST_GATE: assert property (decoder_reset == (!route_serial && decoder_reset_or_serial_tx_in))
		else $error("decoder reset wrongly routed");
	AST_TX_IDLE: assert property ($past(rst) |-> decoder_reset_or_serial_tx_out)
		else $error("tx line not idle after reset");
	AST_VOL_STEP: assert property (!$past(rst) && volume != $past(volume) |->
		volume == $past(volume) + 8'h01 || volume == $past(volume) - 8'h01) else $error("volume jumped");
	AST_VOL_RANGE: assert property (volume <= 8'hfe)
		else $error("volume beyond quietest");
	AST_REQ_PULSE: assert property (fs_req |=> !fs_req)
		else $error("card request longer than one cycle");
	AST_OP_HOLD: assert property (!$past(rst) && !fs_req |-> $stable(fs_op))
		else $error("card op moved without request");
	AST_STOP_REPLY: assert property (play_stop |-> ##[1:1000] !decoder_reset_or_serial_tx_out)
		else $error("no reply after stop");
	AST_STORAGE_LAMP: assert property (mass_storage && $past(mass_storage) |->
		play_status_lamp == $past(card_activity)) else $error("lamp ignores card activity");
	AST_CHARGE_LAMP: assert property ($past(ext_power) && ext_power |->
		battery_level_lamp == $past(charging)) else $error("battery lamp ignores charging");
	AST_PAUSE_BLINK: assert property (play_paused && !mass_storage |-> ##[1:BLINK_WIN]
		($changed(play_status_lamp) || !play_paused || mass_storage)) else $error("lamp not blinking");
endmodule // psc_parser_assertions

bind psc_serial_cmd_parser psc_parser_assertions #(.BLINK_HALF_CYC(BLINK_HALF_CYC),
	.LONG_PRESS_CYC(LONG_PRESS_CYC)) u_chk (.clk, .rst, .route_serial, .decoder_request_or_serial_rx_out,
	.decoder_request_or_serial_rx_oe, .decoder_reset_or_serial_tx_in, .decoder_reset_or_serial_tx_out,
	.decoder_reset_or_serial_tx_oe, .decoder_request, .decoder_reset, .volume, .fs_req, .fs_op,
	.play_stop, .play_paused, .mass_storage, .card_activity, .ext_power, .charging, .play_status_lamp,
	.battery_level_lamp);

// ---- psc_host_model.sv ----
`timescale 1ns/1ps
module psc_host_model (
	input wire logic clk,
	output logic line_to_dut,
	input wire logic line_from_dut,
	output logic [7:0] got_byte,
	output logic got_stb,
	output logic got_frame_ok
);
	localparam int BIT_CYC = psc_pkg::BAUD_DIV;
	logic [7:0] sh;
	initial begin
		line_to_dut = 1'b1;
		got_byte = 8'h00;
		got_stb = 1'b0;
		got_frame_ok = 1'b0;
	end
	// One frame: start low, eight bits LSB first, one stop bit high
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line_to_dut <= fr[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
	endtask
	// Bare line feed ends each command
	task automatic send_line(input string s);
		for (int i = 0; i < s.len(); i++)
			send_byte(8'(s[i]));
		send_byte(8'h0a);
	endtask
	// Mid-bit sampling; a glitch under half a bit is not taken as a start
	always begin
		@(negedge line_from_dut);
		repeat (BIT_CYC / 2) @(posedge clk);
		if (line_from_dut === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk);
				sh[i] = line_from_dut;
			end
			repeat (BIT_CYC) @(posedge clk);
			got_frame_ok <= line_from_dut;
			got_byte <= sh;
			got_stb <= 1'b1;
			@(posedge clk);
			got_stb <= 1'b0;
		end
	end
endmodule // psc_host_model

// ---- player_serial_command_parser_tb.sv ----
`timescale 1ns/1ps
module player_serial_command_parser_tb;
	localparam int LONG = 16;
	localparam int BLINK = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic route_serial = 1'b1;
	logic decoder_request = 1'b0;
	logic host_rst = 1'b0;
	logic [2:0] stk = 3'b000;
	logic mass_storage = 1'b0;
	logic card_activity = 1'b0;
	logic ext_power = 1'b1;
	logic batt_below_3v3 = 1'b0;
	logic charging = 1'b0;
	logic fs_done = 1'b0;
	logic [7:0] vol_prev = 8'h28;
	wire rx_out, rx_oe, tx_out, tx_oe, host_tx, pin3, pin4, decoder_reset, decoder_power, play_stop;
	wire play_paused, fs_req, play_status_lamp, battery_level_lamp, got_stb, got_frame_ok;
	wire [7:0] volume;
	wire [7:0] got_byte;
	psc_pkg::psc_fs_op_t fs_op;
	psc_pkg::psc_fs_op_t exp_op[$];
	logic [7:0] exp_vol[$];
	logic [7:0] exp_byte[$];
	int miscompares = 0;
	int tests_run = 0;
	int n_ops = 0;
	int n_bytes = 0;
	int n_stops = 0;
	int cyc = 0;
	int seed = 32'hed362626;
	int hold;
	int flips;

	always #50 clk = ~clk;
	// Shared pins resolved from the DUT's output enables; the host drives them otherwise
	assign pin3 = rx_oe ? rx_out : host_tx;
	assign pin4 = tx_oe ? tx_out : host_rst;

	psc_serial_cmd_parser #(.BLINK_HALF_CYC(BLINK), .LONG_PRESS_CYC(LONG)) DUT (.clk(clk), .rst(rst),
		.route_serial(route_serial), .decoder_request_or_serial_rx_in(pin3),
		.decoder_request_or_serial_rx_out(rx_out), .decoder_request_or_serial_rx_oe(rx_oe),
		.decoder_reset_or_serial_tx_in(pin4), .decoder_reset_or_serial_tx_out(tx_out),
		.decoder_reset_or_serial_tx_oe(tx_oe), .decoder_request(decoder_request),
		.decoder_reset(decoder_reset), .decoder_power(decoder_power), .play_stop(play_stop),
		.play_paused(play_paused), .volume(volume), .fs_req(fs_req), .fs_op(fs_op), .fs_name(),
		.fs_num(), .fs_done(fs_done), .fs_ok(1'b1), .fs_char(8'h00), .fs_char_valid(1'b0),
		.fs_char_ready(), .fs_dir_mark(1'b0), .fs_end(1'b0), .stick_toward_power_jack(stk[0]),
		.stick_toward_headphones(stk[1]), .stick_pressed(stk[2]), .mass_storage(mass_storage),
		.card_activity(card_activity), .ext_power(ext_power), .batt_below_3v3(batt_below_3v3),
		.charging(charging), .play_status_lamp(play_status_lamp), .battery_level_lamp(battery_level_lamp));
	psc_host_model HOST (.clk(clk), .line_to_dut(host_tx), .line_from_dut(pin4), .got_byte(got_byte),
		.got_stb(got_stb), .got_frame_ok(got_frame_ok));

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_op(input psc_pkg::psc_fs_op_t got, input psc_pkg::psc_fs_op_t exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t card op %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compared %0d, mismatched %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Stick held n cycles: 0 power jack, 1 headphones, 2 pressed
	task automatic stick(input int which, input int n);
		@(posedge clk);
		stk <= 3'b001 << which;
		tick(n);
		stk <= 3'b000;
		tick(3);
	endtask
	// Toggles over 100 settled samples; a half period of 20 gives exactly 5
	task automatic count_flips(input int which, output int f);
		logic last;
		#1; // Off the edge, so the first sample is a settled lamp
		f = 0;
		last = which ? battery_level_lamp : play_status_lamp;
		repeat (100) begin
			@(posedge clk);
			#1;
			if ((which ? battery_level_lamp : play_status_lamp) !== last)
				f++;
			last = which ? battery_level_lamp : play_status_lamp;
		end
	endtask

	// Results taken in arrival order against the notes made while driving
	always @(posedge clk) begin
		vol_prev <= volume;
		if (!rst && fs_req === 1'b1) begin
			n_ops++;
			if (exp_op.size() == 0)
				chk8(8'h01, 8'h00, "unexpected card request");
			else
				chk_op(fs_op, exp_op.pop_front());
		end
		if (!rst && volume !== vol_prev) begin
			if (exp_vol.size() == 0)
				chk8(volume, vol_prev, "volume moved");
			else
				chk8(volume, exp_vol.pop_front(), "volume");
		end
		if (play_stop === 1'b1)
			n_stops++;
		if (got_stb === 1'b1) begin
			n_bytes++;
			chk8({7'h0, got_frame_ok}, 8'h01, "stop bit");
			if (exp_byte.size() == 0)
				chk8(8'h01, 8'h00, "unexpected reply byte");
			else
				chk8(got_byte, exp_byte.pop_front(), "reply byte");
		end
	end

	// Card side answers each request three cycles later
	always @(posedge clk) begin
		fs_done <= 1'b0;
		if (fs_req === 1'b1) begin
			tick(3);
			fs_done <= 1'b1;
		end
	end

	// Run ceiling: three commands, two reply bytes and the sweeps take about 90k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			miscompares++;
			$display("[ERR] %0t run took too long", $time);
			close_out;
		end
	end

	initial begin
		tick(5);
		rst <= 1'b0;
		tick(2);
		#1;
		chk8(volume, 8'h28, "volume after reset");
		chk8({7'h0, decoder_power}, 8'h01, "decoder power after reset");
		chk8({7'h0, tx_out}, 8'h01, "tx idle");
		$display("test done: reset");
		// Direct decoder path: pins must pass straight through
		@(posedge clk);
		route_serial <= 1'b0;
		repeat (8) begin
			@(posedge clk);
			decoder_request <= 1'($random(seed));
			host_rst <= 1'($random(seed));
			#1;
			chk8({6'h0, rx_out, decoder_reset}, {6'h0, decoder_request, host_rst}, "direct path");
		end
		@(posedge clk);
		route_serial <= 1'b1;
		tick(4);
		$display("test done: routing");
		HOST.send_line("+");
		tick(50);
		$display("test done: volume gate");
		exp_op.push_back(psc_pkg::FS_LIST);
		HOST.send_line("L");
		for (int i = 0; i < 2000 && n_ops < 1; i++)
			@(posedge clk);
		$display("test done: listing");
		exp_op.push_back(psc_pkg::FS_NEXT);
		hold = 2 + ($unsigned($random(seed)) % 9);
		stick(0, hold);
		tick(5);
		count_flips(0, flips);
		chk8(8'(flips), 8'h00, "lamp flips while playing");
		chk8({7'h0, play_status_lamp}, 8'h01, "lamp lit while playing");
		$display("test done: next song");
		// Sweep both end stops; the last press of each run must not move
		for (int v = 39; v >= 0; v--)
			exp_vol.push_back(8'(v));
		repeat (41) stick(0, LONG + 4);
		for (int v = 1; v <= 254; v++)
			exp_vol.push_back(8'(v));
		repeat (255) stick(1, LONG + 4);
		chk8(8'(exp_vol.size()), 8'h00, "volume steps missing");
		$display("test done: volume sweep");
		hold = 2 + ($unsigned($random(seed)) % 9);
		stick(2, hold);
		#1;
		chk8({7'h0, play_paused}, 8'h01, "paused by stick");
		count_flips(0, flips);
		chk8(8'(flips), 8'h05, "pause blink");
		repeat (10) begin
			@(posedge clk);
			mass_storage <= 1'b1;
			card_activity <= 1'($random(seed));
		end
		@(posedge clk);
		mass_storage <= 1'b0;
		ext_power <= 1'b0;
		batt_below_3v3 <= 1'b1;
		tick(3);
		count_flips(1, flips);
		chk8(8'(flips), 8'h05, "low battery blink");
		@(posedge clk);
		ext_power <= 1'b1;
		charging <= 1'b1;
		tick(3);
		#1;
		chk8({7'h0, battery_level_lamp}, 8'h01, "charging lamp");
		@(posedge clk);
		charging <= 1'b0;
		tick(3);
		#1;
		chk8({7'h0, battery_level_lamp}, 8'h00, "full lamp");
		$display("test done: lamps");
		stick(2, hold);
		#1;
		chk8({7'h0, play_paused}, 8'h00, "resumed by stick");
		exp_byte.push_back("S");
		exp_byte.push_back("t");
		HOST.send_line("C");
		for (int i = 0; i < 30000 && n_bytes < 2; i++)
			@(posedge clk);
		chk8(8'(n_stops), 8'h01, "stop pulses");
		chk8(8'(exp_byte.size()), 8'h00, "reply bytes missing");
		$display("test done: stop");
		close_out;
	end
endmodule // player_serial_command_parser_tb
